// [io_map_pkg.sv]
// io_map_pkg: shared constants and carrier types for the io function mapper
// assumes one 50 MHz clock domain, synchronous active-high reset
package io_map_pkg;

  localparam int unsigned NUM_IO        = 32;
  localparam int unsigned GROUP_W       = 16;
  localparam int unsigned REG_ADDR_W    = 10;
  localparam int unsigned SYNC_STAGES   = 3;

  // remote word register numbers (Modbus holding registers)
  localparam logic [REG_ADDR_W-1:0] REMOTE_INPUT_WORD_LOW   = 10'h38F;
  localparam logic [REG_ADDR_W-1:0] REMOTE_INPUT_WORD_HIGH  = 10'h390;
  localparam logic [REG_ADDR_W-1:0] REMOTE_OUTPUT_WORD_LOW  = 10'h391;
  localparam logic [REG_ADDR_W-1:0] REMOTE_OUTPUT_WORD_HIGH = 10'h392;
  localparam logic [GROUP_W-1:0]    REMOTE_WORD_RESET       = 16'h0000;

  // primary input function positions on o_primary_in
  localparam int unsigned PIN_RETRACTION      = 0;
  localparam int unsigned PIN_PARTS_CTR_RESET = 1;
  localparam int unsigned PIN_ERROR_RESET     = 2;
  localparam int unsigned PIN_FIRST_INITIATE  = 3;
  localparam int unsigned PIN_INTERLOCK       = 4;
  localparam int unsigned PIN_EDIT_LOCK       = 5;
  localparam int unsigned PIN_ESCAPE          = 6;
  localparam int unsigned PIN_BACK_STEP       = 7;
  localparam int unsigned PIN_SECOND_STAGE    = 8;
  localparam int unsigned PIN_SCHED_SEL_LO    = 9;
  localparam int unsigned PIN_SCHED_SEL_HI    = 15;
  localparam int unsigned PIN_STEPPER_RESET   = 16;
  localparam int unsigned PIN_WELD_CTR_RESET  = 17;
  localparam int unsigned PIN_RETRACT_PB1     = 18;
  localparam int unsigned PIN_RETRACT_PB2     = 19;
  localparam int unsigned PIN_TIP_DRESS       = 20;
  localparam int unsigned PIN_RETRACT_PROX    = 21;
  localparam int unsigned PIN_RETRACT_OPEN    = 22;
  localparam int unsigned NUM_PRIMARY_IN      = 23;
  localparam int unsigned NUM_PRIMARY_OUT     = 12;

  // per-input source and function choices and per-output function choices
  typedef enum logic { SRC_LOCAL = 1'b0, SRC_PLC = 1'b1 } in_source_t;
  typedef enum logic { IN_PRIMARY = 1'b0, IN_SEQUENCER = 1'b1 } in_function_t;
  typedef enum logic [1:0] {
    OUT_PRIMARY   = 2'h0,
    OUT_EVENT     = 2'h1,
    OUT_SEQUENCER = 2'h2,
    OUT_PLC       = 2'h3
  } out_function_t;

  // register write/read request from the Modbus front end
  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [REG_ADDR_W-1:0] addr;
    logic [GROUP_W-1:0]    wdata;
  } reg_req_t;

  typedef struct packed {
    logic               valid;
    logic               err;
    logic [GROUP_W-1:0] rdata;
  } reg_rsp_t;

  // sources that feed the output selectors
  typedef struct packed {
    logic [NUM_PRIMARY_OUT-1:0] primary;
    logic [NUM_IO-1:0]          error_map;
    logic [NUM_IO-1:0]          event_st;
    logic [NUM_IO-1:0]          sequencer;
  } out_sources_t;

endpackage

// [input_synchronizer.sv]
// input_synchronizer: three-stage pin filter, one lane per bit
// assumes asynchronous pin levels; a change is taken once stages two and three agree
`timescale 1ns/1ns
module input_synchronizer #(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  // pins and filtered levels
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [WIDTH-1:0] lvl_d;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      always_comb begin
        lvl_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : lvl_q[g];
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= i_pin;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;
endmodule

// [io_function_mapper.sv]
// io_function_mapper: routes 32 programmable inputs and 32 programmable outputs
// assumes a Modbus front end delivers register requests on the same clock and
// that the menu logic supplies the per-channel selector settings
// and that the event, sequencer and error map sources share this clock
//
// Functional notes
// - There are 32 programmable inputs, each steered to its primary function or to the sequencer.
// - Each input has its own source selector choosing the local port or the PLC bit.
// - Local inputs 1-16 come from the main input port and 17-32 from the expansion port.
// - PLC inputs 1-16 come from register 911 bits 0-15 and 17-32 from register 912.
// - Inputs 1-16 primary functions are retraction through schedule select bits one to seven.
// - Inputs 17-23 have stepper reset through retract open; inputs 24-32 feed only the sequencer.
// - There are 32 programmable outputs, each choosing primary, event, sequencer or PLC.
// - The event choice follows event status and the sequencer choice follows sequencer status.
// - PLC outputs 1-16 come from register 913 bits 0-15 and 17-32 from register 914.
// - Outputs 1-12 carry end of sequence through retract return; outputs 13-16 have no primary.
// - Outputs 17-32 carry the error map as their primary function.
`timescale 1ns/1ns
module io_function_mapper
  import io_map_pkg::*;
(
  // clock and reset
  input  wire logic                               i_mclk,
  input  wire logic                               i_rst,
  // local input port groups (pins)
  input  wire logic [io_map_pkg::GROUP_W-1:0]     i_local_port_main,
  input  wire logic [io_map_pkg::GROUP_W-1:0]     i_local_port_exp,
  // per-channel selectors from the menu settings
  input  wire logic [io_map_pkg::NUM_IO-1:0]      i_in_source_sel,
  input  wire logic [io_map_pkg::NUM_IO-1:0]      i_in_function_sel,
  input  wire logic [2*io_map_pkg::NUM_IO-1:0]    i_out_function_sel,
  // output function sources
  input  wire io_map_pkg::out_sources_t           i_out_sources,
  // Modbus register requests
  input  wire io_map_pkg::reg_req_t               i_reg_req,
  output io_map_pkg::reg_rsp_t                    o_reg_rsp,
  // routed inputs
  output logic [io_map_pkg::NUM_PRIMARY_IN-1:0]   o_primary_in,
  output logic [io_map_pkg::NUM_IO-1:0]           o_sequencer_in,
  // programmable output pins
  output logic [io_map_pkg::NUM_IO-1:0]           o_programmable_output_n
);
  import io_map_pkg::*;

  // remote words
  logic [GROUP_W-1:0] in_lo_q, in_lo_d, in_hi_q, in_hi_d;
  logic [GROUP_W-1:0] out_lo_q, out_lo_d, out_hi_q, out_hi_d;
  reg_rsp_t           rsp_q, rsp_d;
  logic               hit_in_lo;
  logic               hit_in_hi;
  logic               hit_out_lo;
  logic               hit_out_hi;

  // routing state
  logic [NUM_IO-1:0]         local_in;
  logic [NUM_IO-1:0]         remote_in;
  logic [NUM_IO-1:0]         programmable_input_n;
  logic [NUM_IO-1:0]         remote_out;
  logic [NUM_IO-1:0]         primary_out;
  logic [NUM_IO-1:0]         out_d, out_q;
  logic [NUM_IO-1:0]         seq_d, seq_q;
  logic [NUM_IO-1:0]         prim_route;
  logic [NUM_PRIMARY_IN-1:0] prim_d, prim_q;

  // pins cross into this clock here; a level is taken once stages two and
  // three agree, so a pin change reaches the routed outputs five edges later
  input_synchronizer #(
    .WIDTH (NUM_IO)
  ) u_pin_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_pin   ({i_local_port_exp, i_local_port_main}),
    .o_level (local_in)
  );

  // register number decode, one flag per remote word
  // unmatched numbers leave every flag low and answer with err
  always_comb begin
    hit_in_lo  = 1'b0;
    hit_in_hi  = 1'b0;
    hit_out_lo = 1'b0;
    hit_out_hi = 1'b0;
    if (i_reg_req.addr == REMOTE_INPUT_WORD_LOW) begin
      hit_in_lo = 1'b1;
    end else if (i_reg_req.addr == REMOTE_INPUT_WORD_HIGH) begin
      hit_in_hi = 1'b1;
    end else if (i_reg_req.addr == REMOTE_OUTPUT_WORD_LOW) begin
      hit_out_lo = 1'b1;
    end else if (i_reg_req.addr == REMOTE_OUTPUT_WORD_HIGH) begin
      hit_out_hi = 1'b1;
    end
  end

  // register access: writes update a word, reads return it next cycle
  // a write with a read in one request answers the word as it stood before
  always_comb begin
    in_lo_d  = in_lo_q;
    in_hi_d  = in_hi_q;
    out_lo_d = out_lo_q;
    out_hi_d = out_hi_q;
    rsp_d    = '0;
    if (i_reg_req.wr || i_reg_req.rd) begin
      rsp_d.valid = 1'b1;
      if (hit_in_lo) begin
        rsp_d.rdata = in_lo_q;
        if (i_reg_req.wr) begin
          in_lo_d = i_reg_req.wdata;
        end
      end else if (hit_in_hi) begin
        rsp_d.rdata = in_hi_q;
        if (i_reg_req.wr) begin
          in_hi_d = i_reg_req.wdata;
        end
      end else if (hit_out_lo) begin
        rsp_d.rdata = out_lo_q;
        if (i_reg_req.wr) begin
          out_lo_d = i_reg_req.wdata;
        end
      end else if (hit_out_hi) begin
        rsp_d.rdata = out_hi_q;
        if (i_reg_req.wr) begin
          out_hi_d = i_reg_req.wdata;
        end
      end else begin
        rsp_d.err = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      in_lo_q  <= REMOTE_WORD_RESET;
      in_hi_q  <= REMOTE_WORD_RESET;
      out_lo_q <= REMOTE_WORD_RESET;
      out_hi_q <= REMOTE_WORD_RESET;
      rsp_q    <= '0;
    end else begin
      in_lo_q  <= in_lo_d;
      in_hi_q  <= in_hi_d;
      out_lo_q <= out_lo_d;
      out_hi_q <= out_hi_d;
      rsp_q    <= rsp_d;
    end
  end

  // bit 0 of each word is the lowest channel of its group
  assign remote_in  = {in_hi_q, in_lo_q};
  assign remote_out = {out_hi_q, out_lo_q};

  // primary output per channel: 1-12 own functions, 13-16 none, 17-32 error map
  assign primary_out = {i_out_sources.error_map[NUM_IO-1:GROUP_W],
                        {(GROUP_W-NUM_PRIMARY_OUT){1'b0}},
                        i_out_sources.primary};

  genvar g;
  generate
    for (g = 0; g < NUM_IO; g++) begin : g_chan
      always_comb begin
        // source choice per input
        programmable_input_n[g] = (in_source_t'(i_in_source_sel[g]) == SRC_PLC)
                                  ? remote_in[g] : local_in[g];
        // consumer choice per input
        if (in_function_t'(i_in_function_sel[g]) == IN_SEQUENCER) begin
          seq_d[g]      = programmable_input_n[g];
          prim_route[g] = 1'b0;
        end else begin
          seq_d[g]      = 1'b0;
          prim_route[g] = programmable_input_n[g];
        end
        // four-way output choice
        case (out_function_t'(i_out_function_sel[2*g +: 2]))
          OUT_PRIMARY:   out_d[g] = primary_out[g];
          OUT_EVENT:     out_d[g] = i_out_sources.event_st[g];
          OUT_SEQUENCER: out_d[g] = i_out_sources.sequencer[g];
          OUT_PLC:       out_d[g] = remote_out[g];
          default:       out_d[g] = 1'b0;
        endcase
      end
    end
  endgenerate

  // inputs 24-32 have no primary consumer, so only 1-23 reach o_primary_in
  always_comb begin
    prim_d                      = '0;
    prim_d[PIN_RETRACTION]      = prim_route[PIN_RETRACTION];
    prim_d[PIN_PARTS_CTR_RESET] = prim_route[PIN_PARTS_CTR_RESET];
    prim_d[PIN_ERROR_RESET]     = prim_route[PIN_ERROR_RESET];
    prim_d[PIN_FIRST_INITIATE]  = prim_route[PIN_FIRST_INITIATE];
    prim_d[PIN_INTERLOCK]       = prim_route[PIN_INTERLOCK];
    prim_d[PIN_EDIT_LOCK]       = prim_route[PIN_EDIT_LOCK];
    prim_d[PIN_ESCAPE]          = prim_route[PIN_ESCAPE];
    prim_d[PIN_BACK_STEP]       = prim_route[PIN_BACK_STEP];
    prim_d[PIN_SECOND_STAGE]    = prim_route[PIN_SECOND_STAGE];
    // schedule select bits one to seven
    prim_d[PIN_SCHED_SEL_HI:PIN_SCHED_SEL_LO] =
      prim_route[PIN_SCHED_SEL_HI:PIN_SCHED_SEL_LO];
    prim_d[PIN_STEPPER_RESET]   = prim_route[PIN_STEPPER_RESET];
    prim_d[PIN_WELD_CTR_RESET]  = prim_route[PIN_WELD_CTR_RESET];
    prim_d[PIN_RETRACT_PB1]     = prim_route[PIN_RETRACT_PB1];
    prim_d[PIN_RETRACT_PB2]     = prim_route[PIN_RETRACT_PB2];
    prim_d[PIN_TIP_DRESS]       = prim_route[PIN_TIP_DRESS];
    prim_d[PIN_RETRACT_PROX]    = prim_route[PIN_RETRACT_PROX];
    prim_d[PIN_RETRACT_OPEN]    = prim_route[PIN_RETRACT_OPEN];
  end

  // routed results are registered so the pins never show selector glitches
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      prim_q <= '0;
      seq_q  <= '0;
      out_q  <= '0;
    end else begin
      prim_q <= prim_d;
      seq_q  <= seq_d;
      out_q  <= out_d;
    end
  end

  assign o_primary_in            = prim_q;
  assign o_sequencer_in          = seq_q;
  assign o_programmable_output_n = out_q;
  assign o_reg_rsp               = rsp_q;
endmodule

// [io_function_mapper_checker.sv]
// io_function_mapper_checker: routing and register answer timing at the ports
// assumes it is bound to io_function_mapper, one clock, synchronous reset
`timescale 1ns/1ns
module io_function_mapper_checker
  import io_map_pkg::*;
(
  // watched ports
  input wire logic                      i_mclk,
  input wire logic                      i_rst,
  input wire logic [NUM_IO-1:0]         i_in_source_sel,
  input wire logic [NUM_IO-1:0]         i_in_function_sel,
  input wire logic [2*NUM_IO-1:0]       i_out_function_sel,
  input wire out_sources_t              i_out_sources,
  input wire reg_req_t                  i_reg_req,
  input wire reg_rsp_t                  o_reg_rsp,
  input wire logic [NUM_PRIMARY_IN-1:0] o_primary_in,
  input wire logic [NUM_IO-1:0]         o_sequencer_in,
  input wire logic [NUM_IO-1:0]         o_programmable_output_n
);
  logic [GROUP_W-1:0] word_q [4];
  logic [NUM_IO-1:0]  pri_v, exp_o, in_w, m_ip, m_is;
  logic [GROUP_W-1:0] rd_exp;
  logic [1:0]         idx;
  logic               hit, any, arm_q;

  always_comb begin
    pri_v = {i_out_sources.error_map[31:16], 4'h0, i_out_sources.primary};
    for (int g = 0; g < NUM_IO; g++)
      case (i_out_function_sel[2*g +: 2])
        2'h0: exp_o[g] = pri_v[g];
        2'h1: exp_o[g] = i_out_sources.event_st[g];
        2'h2: exp_o[g] = i_out_sources.sequencer[g];
        default: exp_o[g] = g < 16 ? word_q[2][g%16] : word_q[3][g%16];
      endcase
    idx = 2'(i_reg_req.addr - REMOTE_INPUT_WORD_LOW);
    hit = i_reg_req.addr >= REMOTE_INPUT_WORD_LOW && i_reg_req.addr <= REMOTE_OUTPUT_WORD_HIGH;
    any = i_reg_req.wr | i_reg_req.rd;
    rd_exp = word_q[idx];
    in_w = {word_q[1], word_q[0]};
    m_ip = i_in_source_sel & ~i_in_function_sel & 32'h007F_FFFF;
    m_is = i_in_source_sel & i_in_function_sel;
  end

  // shadow of the four remote words
  always_ff @(posedge i_mclk) begin
    arm_q <= !i_rst;
    if (i_rst) word_q <= '{default: REMOTE_WORD_RESET};
    else if (i_reg_req.wr && hit) word_q[idx] <= i_reg_req.wdata;
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst || !arm_q);
  property p_out; o_programmable_output_n == $past(exp_o); endproperty
  a_out: assert property (p_out) else $error("output pin wrong");
  property p_valid; o_reg_rsp.valid == $past(any); endproperty
  a_valid: assert property (p_valid) else $error("answer pulse wrong");
  property p_err; any && !hit |=> o_reg_rsp.err && o_reg_rsp.rdata == '0; endproperty
  a_err: assert property (p_err) else $error("unmapped answer wrong");
  property p_rd; i_reg_req.rd && hit |=> !o_reg_rsp.err && o_reg_rsp.rdata == $past(rd_exp);
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  property p_in_pri; (({9'h0, o_primary_in} ^ $past(in_w)) & $past(m_ip)) == '0; endproperty
  a_in_pri: assert property (p_in_pri) else $error("remote input wrong");
  property p_in_seq; ((o_sequencer_in ^ $past(in_w)) & $past(m_is)) == '0; endproperty
  a_in_seq: assert property (p_in_seq) else $error("remote seq input wrong");
  property p_pri_off;
    $stable(i_in_function_sel) |-> (o_primary_in & i_in_function_sel[22:0]) == '0;
  endproperty
  a_pri_off: assert property (p_pri_off) else $error("primary not released");
  property p_seq_off; $stable(i_in_function_sel) |-> (o_sequencer_in & ~i_in_function_sel) == '0;
  endproperty
  a_seq_off: assert property (p_seq_off) else $error("sequencer not released");
  c_bad: cover property (any && !hit);
  c_plc_in: cover property (m_is != '0 && in_w != '0);
  c_rd: cover property (i_reg_req.rd && hit);
endmodule

// [plc_master_model.sv]
// plc_master_model: remote PLC writing and reading holding registers
// assumes it is the only requester on the register port
`timescale 1ns/1ns
module plc_master_model
  import io_map_pkg::*;
(
  // clock, answer and request
  input  wire logic     i_mclk,
  input  wire reg_rsp_t i_rsp,
  output reg_req_t      o_req
);
  initial o_req = '0;

  // multiple-register write, one word a clock
  task automatic write_block(input logic [REG_ADDR_W-1:0] a, input logic [GROUP_W-1:0] w [4]);
    for (int k = 0; k < 4; k++) begin
      o_req <= '{1'b1, 1'b0, a + REG_ADDR_W'(k), w[k]};
      @(posedge i_mclk);
    end
    o_req <= '{1'b0, 1'b0, ~o_req.addr, ~o_req.wdata};
    @(posedge i_mclk);
  endtask

  task automatic read_reg(input logic [REG_ADDR_W-1:0] a, output logic [GROUP_W-1:0] d,
                          output logic e);
    o_req <= '{1'b0, 1'b1, a, ~o_req.wdata};
    @(posedge i_mclk);
    o_req <= '{1'b0, 1'b0, ~a, ~o_req.wdata};
    @(posedge i_mclk);
    d = i_rsp.rdata;
    e = i_rsp.err;
  endtask
endmodule

// [tb_top.sv]
// tb_top: directed bench for io_function_mapper with a PLC model
// assumes package, checker and model files compiled first
`timescale 1ns/1ns
module tb_top;
  import io_map_pkg::*;
  logic                      i_mclk = 1'b0;
  logic                      i_rst = 1'b1;
  logic [GROUP_W-1:0]        pm = 16'h9C35, pe = 16'hFFC7;
  logic [NUM_IO-1:0]         src = '0, fn = '0, pins, sq;
  logic [2*NUM_IO-1:0]       osel = '0;
  logic [NUM_PRIMARY_IN-1:0] pri;
  out_sources_t              os = '{12'hA5B, 32'h6C3E_9F00, 32'h0FF0_33CC, 32'hF00F_5A5A};
  reg_req_t                  req;
  reg_rsp_t                  rsp;
  logic [GROUP_W-1:0]        w [4] = '{16'h1234, 16'h8001, 16'h00F0, 16'hC30F};
  int                        bad_count = 0, total_checks = 0, cycles = 0;

  always #10 i_mclk = ~i_mclk;
  io_function_mapper i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_local_port_main(pm),
    .i_local_port_exp(pe), .i_in_source_sel(src), .i_in_function_sel(fn),
    .i_out_function_sel(osel), .i_out_sources(os), .i_reg_req(req), .o_reg_rsp(rsp),
    .o_primary_in(pri), .o_sequencer_in(sq), .o_programmable_output_n(pins));
  plc_master_model i_plc (.i_mclk(i_mclk), .i_rsp(rsp), .o_req(req));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // reset words, block write, read back, unmapped neighbours
  task automatic t_regs();
    logic [GROUP_W-1:0] d;
    logic               e;
    logic [31:0]        exp;
    for (int p = 0; p < 2; p++) begin
      if (p == 1) i_plc.write_block(REMOTE_INPUT_WORD_LOW, w);
      for (int k = 0; k < 6; k++) begin
        i_plc.read_reg(REMOTE_INPUT_WORD_LOW - 10'h1 + 10'(k), d, e);
        exp = 32'h0001_0000;
        if (k > 0 && k < 5) exp = {16'h0, p == 1 ? w[k-1] : REMOTE_WORD_RESET};
        chk({15'h0, e, d}, exp, "register word");
      end
    end
  endtask

  // per-input source and function choice
  task automatic t_inputs(input logic [31:0] s, input logic [31:0] f);
    logic [31:0] mix;
    src <= s;
    fn <= f;
    repeat (8) @(posedge i_mclk);
    mix = ({pe, pm} & ~s) | ({w[1], w[0]} & s);
    chk({9'h0, pri}, mix & ~f & 32'h007F_FFFF, "primary in");
    chk(sq, mix & f, "sequencer in");
  endtask

  // local pin change: held by the filter and output register for five edges, then routed
  task automatic t_pin_edge();
    logic [31:0] prev;
    src <= '0;
    fn <= '0;
    repeat (8) @(posedge i_mclk);
    prev = {pe, pm};
    chk({9'h0, pri}, prev & 32'h007F_FFFF, "pins settled");
    pm <= pm ^ 16'h0001;
    pe <= pe ^ 16'h0001;
    repeat (5) @(posedge i_mclk);
    chk({9'h0, pri}, prev & 32'h007F_FFFF, "pins still filtered");
    @(posedge i_mclk);
    chk({9'h0, pri}, {pe, pm} & 32'h007F_FFFF, "pins routed");
  endtask

  // per-output function choice
  task automatic t_outputs(input logic [63:0] s);
    logic [31:0] exp;
    logic [31:0] pv;
    osel <= s;
    repeat (3) @(posedge i_mclk);
    pv = {os.error_map[31:16], 4'h0, os.primary};
    for (int g = 0; g < 32; g++)
      case (s[2*g +: 2])
        2'h0: exp[g] = pv[g];
        2'h1: exp[g] = os.event_st[g];
        2'h2: exp[g] = os.sequencer[g];
        default: exp[g] = g < 16 ? w[2][g%16] : w[3][g%16];
      endcase
    chk(pins, exp, "output pins");
  endtask

  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    chk(pins, 32'h0, "pins after reset");
    chk({9'h0, pri}, 32'h0, "primary after reset");
    chk(sq, 32'h0, "sequencer after reset");
    t_regs();
    t_inputs(32'h0, 32'h0);
    t_inputs(32'hFFFF_FFFF, 32'h0);
    t_inputs(32'h5555_5555, 32'h0F0F_0F0F);
    t_inputs(32'hAAAA_AAAA, 32'hFFFF_FFFF);
    for (int c = 0; c < 4; c++) t_outputs({32{2'(c)}});
    t_outputs({8{8'hE4}});
    t_pin_edge();
    report_and_stop();
  end
endmodule

bind io_function_mapper io_function_mapper_checker i_chk (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_in_source_sel(i_in_source_sel), .i_in_function_sel(i_in_function_sel),
  .i_out_function_sel(i_out_function_sel), .i_out_sources(i_out_sources),
  .i_reg_req(i_reg_req), .o_reg_rsp(o_reg_rsp), .o_primary_in(o_primary_in),
  .o_sequencer_in(o_sequencer_in), .o_programmable_output_n(o_programmable_output_n));
